/* File: src/hs_timer_pkg.sv */
// Shared constants, field positions and mode codes of the high-speed timer output control.
package hs_timer_pkg;

    // Register byte addresses on the AXI4-Lite bus.
    localparam int unsigned ADDR_W          = 12;
    localparam logic [11:0] ADDR_OUT_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_CLK_CTRL   = 12'h004;
    localparam logic [11:0] ADDR_SHADOW     = 12'h008;
    localparam logic [11:0] ADDR_WAVE_MODE  = 12'h00C;
    localparam logic [11:0] ADDR_STATUS     = 12'h010;

    // Field positions of pwm_output_control.
    localparam int unsigned OC_A_MODE_HI    = 7;
    localparam int unsigned OC_A_MODE_LO    = 6;
    localparam int unsigned OC_B_MODE_HI    = 5;
    localparam int unsigned OC_B_MODE_LO    = 4;
    localparam int unsigned OC_FORCE_A      = 3;
    localparam int unsigned OC_FORCE_B      = 2;
    localparam int unsigned OC_PWM_A        = 1;
    localparam int unsigned OC_PWM_B        = 0;

    // Field positions of clock_deadtime_control.
    localparam int unsigned CC_INVERT       = 7;
    localparam int unsigned CC_PSR          = 6;
    localparam int unsigned CC_DT_HI        = 5;
    localparam int unsigned CC_DT_LO        = 4;
    localparam int unsigned CC_CS_HI        = 3;
    localparam int unsigned CC_CS_LO        = 0;

    // Field positions of the wave mode register.
    localparam int unsigned WM_HI           = 1;
    localparam int unsigned WM_LO           = 0;

    // Reset value of every register.
    localparam logic [7:0]  REG_RESET       = 8'h00;

    // Output-mode codes.
    localparam logic [1:0]  OM_NORMAL       = 2'h0;
    localparam logic [1:0]  OM_TOGGLE       = 2'h1;
    localparam logic [1:0]  OM_CLEAR        = 2'h2;
    localparam logic [1:0]  OM_SET          = 2'h3;

    // Clock select codes that stop the timer or pass the source undivided.
    localparam logic [3:0]  CS_STOP         = 4'h0;
    localparam logic [3:0]  CS_DIV1         = 4'h1;

    // Prescaler and dead-time divider widths.
    localparam int unsigned PRESC_W         = 14;
    localparam int unsigned DT_W            = 3;

    // AXI response codes.
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Waveform behaviour of one channel.
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_SINGLE = 3'b010,
        MODE_DUAL   = 3'b100
    } chan_mode_e;

endpackage

/* File: src/hs_timer_output_clock_control.sv */
// Output-mode, force, PWM enable, prescaler and dead-time control of the high-speed timer.
//
// Summary of operation
// - Nonzero channel B output mode makes the compare output take over its pin.
// - Complement B pin connects only in PWM with channel B mode 01.
// - Non-PWM B modes: 00 none, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM B codes 01/10: clear on match, set at counter zero.
// - Fast PWM B code 11: set on match, clear at counter zero.
// - Dual-slope B codes 01/10: clear on up-match, set on down-match.
// - Dual-slope B code 11: set on up-match, clear on down-match.
// - B PWM enable and low wave mode bit select the B mode meaning.
// - Channel A force works only in non-PWM; ignored while A PWM enabled.
// - A force applies A mode action like a match, same-cycle mode, reads zero.
// - B force acts only in non-PWM, like a match, same-cycle mode.
// - B force bit always reads back as zero.
// - Each channel PWM enable puts that channel into PWM on its compare.
// - Invert bit inverts both true and complement outputs.
// - Prescaler reset clears the prescaler and the dead-time divider count, self-clears, reads zero.
// - Dead-time divider divides the timer clock by 1, 2, 4 or 8.
// - Clock select 1..15 divides the chosen source by two to code minus one.
// - Clock select zero stops the timer clock.
// - Shadow bits 7:6 mirror the A mode, 5:4 the B mode.
// - PWM off is normal mode; wave mode picks the PWM flavour.
`timescale 1ns/1ps
`default_nettype none

module hs_timer_output_clock_control #(
    parameter int unsigned COUNT_W = 10
) (
    // Clock and reset.
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address and data.
    input  wire logic [11:0]          awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    // AXI4-Lite write response.
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    // AXI4-Lite read.
    input  wire logic [11:0]          araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    // Counter and comparator side.
    input  wire logic [COUNT_W-1:0]   counter_value,
    input  wire logic                 count_down,
    input  wire logic                 chan_a_match,
    input  wire logic                 chan_b_match,
    // Clock source choice.
    input  wire logic                 async_mode,
    input  wire logic                 fast_pll_clock_en,
    // Timer clock and counter control.
    output logic                      timer_tick,
    output logic                      deadtime_tick,
    output logic                      timer_running,
    output logic [1:0]                wave_mode,
    output logic                      chan_a_pwm_enable,
    output logic                      chan_b_pwm_enable,
    // Waveforms and pins.
    output logic                      chan_a_waveform,
    output logic                      chan_b_waveform,
    output logic                      chan_a_pin_out,
    output logic                      chan_a_pin_out_n,
    output logic                      chan_a_pin_sel,
    output logic                      chan_a_pin_n_sel,
    output logic                      chan_b_pin_out,
    output logic                      chan_b_pin_out_n,
    output logic                      chan_b_pin_sel,
    output logic                      chan_b_pin_n_sel
);

    // Whole state of the block; index 0 is channel A, index 1 is channel B.
    typedef struct packed {
        logic                                   aw_held;
        logic [11:0]                            awaddr;
        logic                                   w_held;
        logic [7:0]                             wdata;
        logic                                   wlane;
        logic                                   bvalid;
        logic [1:0]                             bresp;
        logic                                   rvalid;
        logic [7:0]                             rdata;
        logic [1:0]                             rresp;
        logic [1:0][1:0]                        om;
        logic [1:0]                             pwm;
        logic                                   invert;
        logic [1:0]                             dt_div;
        logic [3:0]                             cs;
        logic [1:0]                             wm;
        logic [1:0]                             wave;
        logic [1:0]                             pin_t;
        logic [1:0]                             pin_c;
        logic [1:0]                             sel_t;
        logic [1:0]                             sel_c;
        logic [hs_timer_pkg::PRESC_W-1:0]       presc;
        logic [hs_timer_pkg::DT_W-1:0]          dt_cnt;
        logic                                   tick;
        logic                                   dt_tick;
    } state_s;

    state_s                             q;
    state_s                             d;
    logic [11:0]                        wr_addr;
    logic [11:0]                        rd_addr;
    logic                               do_write;
    logic                               wr_en;
    logic                               wr_out;
    logic                               wr_clk;
    logic                               wr_shadow;
    logic                               wr_wave;
    logic                               wr_hit;
    logic                               rd_hit;
    logic [7:0]                         rd_byte;
    logic                               psr;
    logic [1:0][1:0]                    om_new;
    logic [1:0]                         pwm_new;
    logic [1:0]                         force_new;
    logic [1:0]                         match_vec;
    logic [1:0]                         wm_new;
    logic                               inv_new;
    logic [1:0]                         wave_nx;
    logic                               at_zero;
    logic                               src_en;
    logic [hs_timer_pkg::PRESC_W-1:0]   ps_mask;
    logic [hs_timer_pkg::DT_W-1:0]      dt_mask;

    // Next waveform level of one channel after match, zero and force events.
    function automatic logic wave_next(
        input hs_timer_pkg::chan_mode_e mode,
        input logic [1:0]               om,
        input logic                     w,
        input logic                     match,
        input logic                     frc,
        input logic                     zero,
        input logic                     down
    );
        logic r;
        r = w;
        unique case (mode)
            hs_timer_pkg::MODE_NORMAL: begin
                if (match || frc) begin
                    unique case (om)
                        hs_timer_pkg::OM_NORMAL: r = w;
                        hs_timer_pkg::OM_TOGGLE: r = ~w;
                        hs_timer_pkg::OM_CLEAR:  r = 1'b0;
                        hs_timer_pkg::OM_SET:    r = 1'b1;
                    endcase
                end
            end
            hs_timer_pkg::MODE_SINGLE: begin
                // A match in the zero cycle wins, so a tiny duty still shows.
                if (om != hs_timer_pkg::OM_NORMAL) begin
                    if (zero) begin
                        r = (om != hs_timer_pkg::OM_SET);
                    end
                    if (match) begin
                        r = (om == hs_timer_pkg::OM_SET);
                    end
                end
            end
            hs_timer_pkg::MODE_DUAL: begin
                if ((om != hs_timer_pkg::OM_NORMAL) && match) begin
                    r = (om == hs_timer_pkg::OM_SET) ^ down;
                end
            end
            default: r = w;
        endcase
        return r;
    endfunction

    // Write decode; a write lands once both address and data are held.
    assign wr_addr   = {q.awaddr[11:2], 2'h0};
    assign rd_addr   = {araddr[11:2], 2'h0};
    assign do_write  = q.aw_held && q.w_held && !q.bvalid;
    assign wr_en     = do_write && q.wlane;
    assign wr_out    = wr_en && (wr_addr == hs_timer_pkg::ADDR_OUT_CTRL);
    assign wr_clk    = wr_en && (wr_addr == hs_timer_pkg::ADDR_CLK_CTRL);
    assign wr_shadow = wr_en && (wr_addr == hs_timer_pkg::ADDR_SHADOW);
    assign wr_wave   = wr_en && (wr_addr == hs_timer_pkg::ADDR_WAVE_MODE);
    assign wr_hit    = (wr_addr == hs_timer_pkg::ADDR_OUT_CTRL)
                    || (wr_addr == hs_timer_pkg::ADDR_CLK_CTRL)
                    || (wr_addr == hs_timer_pkg::ADDR_SHADOW)
                    || (wr_addr == hs_timer_pkg::ADDR_WAVE_MODE)
                    || (wr_addr == hs_timer_pkg::ADDR_STATUS);

    // Field values as they stand after this cycle's write, so a force sees them.
    assign om_new[0] = (wr_out || wr_shadow)
                     ? q.wdata[hs_timer_pkg::OC_A_MODE_HI:hs_timer_pkg::OC_A_MODE_LO] : q.om[0];
    assign om_new[1] = (wr_out || wr_shadow)
                     ? q.wdata[hs_timer_pkg::OC_B_MODE_HI:hs_timer_pkg::OC_B_MODE_LO] : q.om[1];
    assign pwm_new[0] = wr_out ? q.wdata[hs_timer_pkg::OC_PWM_A] : q.pwm[0];
    assign pwm_new[1] = wr_out ? q.wdata[hs_timer_pkg::OC_PWM_B] : q.pwm[1];
    assign force_new[0] = wr_out && q.wdata[hs_timer_pkg::OC_FORCE_A] && !pwm_new[0];
    assign force_new[1] = wr_out && q.wdata[hs_timer_pkg::OC_FORCE_B] && !pwm_new[1];
    assign wm_new   = wr_wave ? q.wdata[hs_timer_pkg::WM_HI:hs_timer_pkg::WM_LO] : q.wm;
    assign inv_new  = wr_clk ? q.wdata[hs_timer_pkg::CC_INVERT] : q.invert;
    assign psr      = wr_clk && q.wdata[hs_timer_pkg::CC_PSR];
    assign match_vec = {chan_b_match, chan_a_match};
    assign at_zero  = (counter_value == '0);

    // Per-channel mode decode and waveform step.
    for (genvar i = 0; i < 2; i++) begin : g_chan
        hs_timer_pkg::chan_mode_e mode;
        assign mode = !pwm_new[i] ? hs_timer_pkg::MODE_NORMAL
                    : wm_new[hs_timer_pkg::WM_LO] ? hs_timer_pkg::MODE_DUAL
                    : hs_timer_pkg::MODE_SINGLE;
        assign wave_nx[i] = wave_next(mode, om_new[i], q.wave[i], match_vec[i],
                                      force_new[i], at_zero, count_down);
    end

    // Read data; the strobe bits and the prescaler reset always read zero.
    assign rd_hit  = (rd_addr == hs_timer_pkg::ADDR_OUT_CTRL)
                  || (rd_addr == hs_timer_pkg::ADDR_CLK_CTRL)
                  || (rd_addr == hs_timer_pkg::ADDR_SHADOW)
                  || (rd_addr == hs_timer_pkg::ADDR_WAVE_MODE)
                  || (rd_addr == hs_timer_pkg::ADDR_STATUS);
    assign rd_byte = (rd_addr == hs_timer_pkg::ADDR_OUT_CTRL)
                   ? {q.om[0], q.om[1], 2'h0, q.pwm[0], q.pwm[1]}
                   : (rd_addr == hs_timer_pkg::ADDR_CLK_CTRL)
                   ? {q.invert, 1'b0, q.dt_div, q.cs}
                   : (rd_addr == hs_timer_pkg::ADDR_SHADOW)
                   ? {q.om[0], q.om[1], 4'h0}
                   : (rd_addr == hs_timer_pkg::ADDR_WAVE_MODE)
                   ? {6'h00, q.wm}
                   : (rd_addr == hs_timer_pkg::ADDR_STATUS)
                   ? {1'b0, (q.cs != hs_timer_pkg::CS_STOP), q.wave[1], q.wave[0],
                      q.sel_c[1], q.sel_t[1], q.sel_c[0], q.sel_t[0]}
                   : 8'h00;

    // Prescaler tap: code n takes every 2^(n-1)th source cycle.
    assign src_en  = async_mode ? fast_pll_clock_en : 1'b1;
    assign ps_mask = ~(14'h3FFF << (q.cs - 4'h1));
    assign dt_mask = ~(3'h7 << q.dt_div);

    // Next state of the bus slave, registers, waveforms and dividers.
    always_comb begin
        d = q;
        if (awvalid && awready) begin
            d.aw_held = 1'b1;
            d.awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            d.w_held = 1'b1;
            d.wdata  = wdata[7:0];
            d.wlane  = wstrb[0];
        end
        if (do_write) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = wr_hit ? hs_timer_pkg::RESP_OKAY : hs_timer_pkg::RESP_SLVERR;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rdata  = rd_byte;
            d.rresp  = rd_hit ? hs_timer_pkg::RESP_OKAY : hs_timer_pkg::RESP_SLVERR;
        end
        // Registers; strobes are not stored, so they cannot read back.
        d.om     = om_new;
        d.pwm    = pwm_new;
        d.wm     = wm_new;
        d.invert = inv_new;
        if (wr_clk) begin
            d.dt_div = q.wdata[hs_timer_pkg::CC_DT_HI:hs_timer_pkg::CC_DT_LO];
            d.cs     = q.wdata[hs_timer_pkg::CC_CS_HI:hs_timer_pkg::CC_CS_LO];
        end
        // Waveforms and pin routing; the pins follow the new waveform at once.
        d.wave = wave_nx;
        for (int i = 0; i < 2; i++) begin
            d.pin_t[i] = wave_nx[i] ^ inv_new;
            d.pin_c[i] = ~wave_nx[i] ^ inv_new;
            d.sel_t[i] = (om_new[i] != hs_timer_pkg::OM_NORMAL);
            d.sel_c[i] = pwm_new[i] && (om_new[i] == hs_timer_pkg::OM_TOGGLE);
        end
        // Prescaler; a reset restarts the divide phase but leaves the counter alone.
        d.tick = (q.cs != hs_timer_pkg::CS_STOP) && src_en && !psr
              && ((q.presc & ps_mask) == ps_mask);
        if (psr) begin
            d.presc = '0;
        end else if (src_en) begin
            d.presc = q.presc + 14'h0001;
        end
        // Dead-time divider counts timer ticks.
        d.dt_tick = d.tick && ((q.dt_cnt & dt_mask) == dt_mask);
        if (psr) begin
            d.dt_cnt = '0;
        end else if (d.tick) begin
            d.dt_cnt = q.dt_cnt + 3'h1;
        end
    end

    // State register; every field resets to zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs; all data outputs come straight from the state register.
    assign awready           = !q.aw_held && !q.bvalid;
    assign wready            = !q.w_held && !q.bvalid;
    assign bvalid            = q.bvalid;
    assign bresp             = q.bresp;
    assign arready           = !q.rvalid;
    assign rvalid            = q.rvalid;
    assign rdata             = {24'h000000, q.rdata};
    assign rresp             = q.rresp;
    assign timer_tick        = q.tick;
    assign deadtime_tick     = q.dt_tick;
    assign timer_running     = (q.cs != hs_timer_pkg::CS_STOP);
    assign wave_mode         = q.wm;
    assign chan_a_pwm_enable = q.pwm[0];
    assign chan_b_pwm_enable = q.pwm[1];
    assign chan_a_waveform   = q.wave[0];
    assign chan_b_waveform   = q.wave[1];
    assign chan_a_pin_out    = q.pin_t[0];
    assign chan_a_pin_out_n  = q.pin_c[0];
    assign chan_a_pin_sel    = q.sel_t[0];
    assign chan_a_pin_n_sel  = q.sel_c[0];
    assign chan_b_pin_out    = q.pin_t[1];
    assign chan_b_pin_out_n  = q.pin_c[1];
    assign chan_b_pin_sel    = q.sel_t[1];
    assign chan_b_pin_n_sel  = q.sel_c[1];

    // Checks on the block's own behaviour.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence both_taken_s;
        awvalid && awready && wvalid && wready;
    endsequence

    sequence write_landed_s;
        ##2 bvalid;
    endsequence

    write_resp_timing_a: assert property (both_taken_s |-> write_landed_s)
        else $error("Write response not two cycles after address and data.");

    force_a_ignored_a: assert property (
        (wr_out && q.wdata[hs_timer_pkg::OC_FORCE_A] && q.wdata[hs_timer_pkg::OC_PWM_A]
         && !chan_a_match && !at_zero) |=> $stable(chan_a_waveform))
        else $error("Channel A force acted while PWM was enabled.");

    force_a_toggle_a: assert property (
        (wr_out && q.wdata[hs_timer_pkg::OC_FORCE_A] && !q.wdata[hs_timer_pkg::OC_PWM_A]
         && (q.wdata[hs_timer_pkg::OC_A_MODE_HI:hs_timer_pkg::OC_A_MODE_LO]
             == hs_timer_pkg::OM_TOGGLE)) |=> (chan_a_waveform != $past(chan_a_waveform)))
        else $error("Channel A force did not toggle with same-cycle mode.");

    force_b_set_a: assert property (
        (wr_out && q.wdata[hs_timer_pkg::OC_FORCE_B] && !q.wdata[hs_timer_pkg::OC_PWM_B]
         && (q.wdata[hs_timer_pkg::OC_B_MODE_HI:hs_timer_pkg::OC_B_MODE_LO]
             == hs_timer_pkg::OM_SET)) |=> (chan_b_waveform && chan_b_pin_sel))
        else $error("Channel B force did not set the output.");

    comp_b_route_a: assert property (
        chan_b_pin_n_sel |-> (chan_b_pwm_enable && chan_b_pin_sel))
        else $error("Channel B complement routed outside PWM mode 01.");

    fast_b_zero_a: assert property (
        (!do_write && q.pwm[1] && !q.wm[hs_timer_pkg::WM_LO] && q.om[1] != hs_timer_pkg::OM_SET
         && q.om[1] != hs_timer_pkg::OM_NORMAL && at_zero && !chan_b_match) |=> chan_b_waveform)
        else $error("Fast PWM channel B not set at counter zero.");

    fast_b_match_a: assert property (
        (!do_write && q.pwm[1] && !q.wm[hs_timer_pkg::WM_LO] && q.om[1] == hs_timer_pkg::OM_SET
         && chan_b_match) |=> (chan_b_waveform && chan_b_pin_out == !chan_b_pin_out_n))
        else $error("Fast PWM channel B code 11 not set on match.");

    dual_b_match_a: assert property (
        (!do_write && q.pwm[1] && q.wm[hs_timer_pkg::WM_LO] && q.om[1] == hs_timer_pkg::OM_TOGGLE
         && chan_b_match) |=> (chan_b_waveform == $past(count_down)))
        else $error("Dual-slope channel B codes 01 wrong on match.");

    dual_b_set_a: assert property (
        (!do_write && q.pwm[1] && q.wm[hs_timer_pkg::WM_LO] && q.om[1] == hs_timer_pkg::OM_SET
         && chan_b_match) |=> (chan_b_waveform != $past(count_down)))
        else $error("Dual-slope channel B code 11 wrong on match.");

    presc_reset_a: assert property (psr |=> (q.presc == '0 && !timer_tick))
        else $error("Prescaler reset did not clear the prescaler.");

    stop_no_tick_a: assert property (
        (q.cs == hs_timer_pkg::CS_STOP && !do_write) [*2] |=> !timer_tick)
        else $error("Timer clock ran while stopped.");

    div1_tick_a: assert property (
        (q.cs == hs_timer_pkg::CS_DIV1 && !async_mode && !do_write) |=> timer_tick)
        else $error("Divide-by-one sync clock missed a tick.");

    dt_inside_a: assert property (deadtime_tick |-> timer_tick)
        else $error("Dead-time tick without a timer tick.");

endmodule

`default_nettype wire

/* File: bench/hs_timer_output_clock_control_tb_top.sv */
// Self-checking bench of the timer output and clock control.
`timescale 1ns/1ps
`default_nettype none
module hs_timer_output_clock_control_tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, count_down;
    logic        chan_b_match, awready, wready, bvalid, arready, rvalid, timer_tick;
    logic        deadtime_tick, timer_running, chan_a_waveform, chan_b_waveform;
    logic        chan_b_pin_out, chan_b_pin_out_n, chan_b_pin_sel, chan_b_pin_n_sel, async_mode;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [9:0]  counter_value;
    int          err_total, n_checks, t, d;

    // Outputs not judged here stay open.
    hs_timer_output_clock_control u_hs_timer_output_clock_control (.aclk, .aresetn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .counter_value,
        .count_down, .chan_a_match(1'b0), .chan_b_match, .async_mode,
        .fast_pll_clock_en(1'b0), .timer_tick, .deadtime_tick, .timer_running, .wave_mode(),
        .chan_a_pwm_enable(), .chan_b_pwm_enable(), .chan_a_waveform, .chan_b_waveform,
        .chan_a_pin_out(), .chan_a_pin_out_n(), .chan_a_pin_sel(), .chan_a_pin_n_sel(),
        .chan_b_pin_out, .chan_b_pin_out_n, .chan_b_pin_sel, .chan_b_pin_n_sel);

    // Ends the run.
    task automatic give_verdict();
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [7:0] g, e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: %h not %h", $time, g, e);
        end
    endtask
    // Bounded wait at falling edges, so a hung handshake cannot stall the run.
    task automatic hold(ref logic s);
        @(negedge aclk);
        for (int i = 0; i < 64 && s !== 1'b1; i++) @(negedge aclk);
        if (s !== 1'b1) begin
            err_total++;
            give_verdict();
        end
    endtask
    // Write; both channels offered together.
    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic bad);
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h000000, v}; awvalid <= 1'b1; wvalid <= 1'b1;
        hold(awready);
        @(posedge aclk);
        awvalid <= 1'b0; wvalid <= 1'b0; bready <= 1'b1;
        hold(bvalid);
        chk({6'h00, bresp}, bad ? 8'h02 : 8'h00);
        @(posedge aclk);
        bready <= 1'b0;
        @(negedge aclk);
    endtask
    // Read with data and response checked.
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic bad);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        hold(arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        hold(rvalid);
        chk(rdata[7:0], e);
        chk({6'h00, rresp}, bad ? 8'h02 : 8'h00);
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // One-cycle counter event, then the channel B waveform is judged.
    task automatic ev(input logic z, m, dn, input logic [7:0] e);
        @(posedge aclk);
        counter_value <= z ? 10'h000 : 10'h005; chan_b_match <= m; count_down <= dn;
        @(posedge aclk);
        counter_value <= 10'h005; chan_b_match <= 1'b0;
        @(negedge aclk);
        chk(8'(chan_b_waveform), e);
    endtask
    // Reset value, unmapped place, mode alias.
    task automatic t_regs();
        rd(12'h004, 8'h00, 0);
        rd(12'h100, 8'h00, 1);
        wr(12'h100, 8'hFF, 1);
        wr(12'h008, 8'hF0, 0);
        rd(12'h000, 8'hF0, 0);
    endtask
    // Forced actions for codes 11, 10, 01, 01, 00; channel A force gated by PWM.
    task automatic t_force();
        for (int i = 0; i < 5; i++) begin
            wr(12'h000, {2'h0, 2'(10'h05B >> (2 * i)), 4'h4}, 0);
            chk(8'(chan_b_waveform), 8'(5'h05 >> i) & 8'h01);
            chk(8'(chan_b_pin_sel), 8'(i < 4));
        end
        rd(12'h000, 8'h00, 0);
        wr(12'h000, 8'hCA, 0);
        chk(8'(chan_a_waveform), 8'h00);
        wr(12'h000, 8'hC8, 0);
        chk(8'(chan_a_waveform), 8'h01);
        wr(12'h000, 8'h48, 0);
        chk(8'(chan_a_waveform), 8'h00);
    endtask
    // Fast PWM, then phase-correct, then normal mode again.
    task automatic t_pwm();
        wr(12'h000, 8'h11, 0);
        chk(8'(chan_b_pin_n_sel), 8'h01);
        rd(12'h010, 8'h0C, 0);
        ev(1, 0, 0, 8'h01);
        ev(0, 1, 0, 8'h00);
        wr(12'h000, 8'h31, 0);
        chk(8'(chan_b_pin_n_sel), 8'h00);
        ev(0, 1, 0, 8'h01);
        ev(1, 0, 0, 8'h00);
        wr(12'h00C, 8'h01, 0);
        ev(0, 1, 0, 8'h01);
        ev(0, 1, 1, 8'h00);
        wr(12'h000, 8'h21, 0);
        ev(0, 1, 0, 8'h00);
        ev(0, 1, 1, 8'h01);
        wr(12'h000, 8'h20, 0);
        ev(0, 1, 1, 8'h00);
    endtask
    // Inversion, prescaler reset, divider counts over 32 cycles, stop.
    task automatic t_clock();
        wr(12'h004, 8'h80, 0);
        chk(8'(chan_b_pin_out), 8'h01);
        chk(8'(chan_b_pin_out_n), 8'h00);
        for (int n = 1; n < 4; n++) begin
            wr(12'h004, {2'h1, 2'(n - 1), 4'(n)}, 0);
            rd(12'h004, {2'h0, 2'(n - 1), 4'(n)}, 0);
            t = 0;
            d = 0;
            repeat (32) begin
                @(negedge aclk);
                t += int'(timer_tick);
                d += int'(deadtime_tick);
            end
            chk(8'(t), 8'(32 >> (n - 1)));
            chk(8'(d), 8'(32 >> (2 * n - 2)));
        end
        // A stalled fast clock in asynchronous mode must give no ticks.
        @(posedge aclk);
        async_mode <= 1'b1;
        @(posedge aclk);
        t = 0;
        repeat (32) begin
            @(negedge aclk);
            t += int'(timer_tick);
        end
        chk(8'(t), 8'h00);
        wr(12'h004, 8'h00, 0);
        chk(8'(timer_running), 8'h00);
    endtask
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // Ten reset cycles, then the scenarios.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, count_down, chan_b_match} = '0;
        {awaddr, araddr, wdata, err_total, n_checks, async_mode} = '0;
        counter_value = 10'h005;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_force();
        t_pwm();
        t_clock();
        give_verdict();
    end
endmodule
`default_nettype wire
